// [bst_defs.svh]
// constants for the boundary-scan test logic
// assumes inclusion by every design file that needs it
// How it works
// - EXTEST selects the boundary chain; capture-DR loads function inputs on rising TCK
// - EXTEST outputs come only from update stage, set in update-DR on falling TCK, reaching pins on later MCLK edges
// - EXTEST shift-DR moves boundary chain contents out on TDO
// - IDCODE at update-IR selects identification register; chain back to normal
// - IDCODE loads identification value in capture-DR, shifts it out in shift-DR
// - identification is 32 bits: version, part, maker, bit 0 set
// - HIGHZ floats all three-state outputs and turns bidirectional pins to inputs
// - float starts at update-IR and lasts until another instruction is updated
// - HIGHZ routes TDI to TDO through the one-stage bypass register
// - SAMPLE/PRELOAD captures all pins without disturbing normal operation
// - SAMPLE/PRELOAD shifts new TDI values into the chain for later EXTEST
// - BYPASS after update-IR selects bypass and keeps the chain normal
// - BYPASS captures zero in capture-DR and shifts through it in shift-DR
// - under BYPASS the captured zero is the first bit on TDO
// - under BYPASS, update-DR leaves the chain's update stage unchanged
// - bypass register is exactly one shift stage
// - chain holds a cell for every digital function pin
// - three-state input has own cell; its blocking is suppressed in EXTEST
// - four-bit instruction; listed codes; unknown codes select bypass and float
// - IDCODE loaded into instruction register at power-up and in reset state
// - sixteen-state controller on rising TCK; reset by TRST low or five TMS highs
// - TDO driven only in shift-DR or shift-IR
`ifndef BST_DEFS_SVH
`define BST_DEFS_SVH
`define BST_IR_W 4
`define BST_IR_EXTEST 4'h0
`define BST_IR_IDCODE 4'h1
`define BST_IR_HIGHZ 4'h4
`define BST_IR_SAMPLE 4'h5
`define BST_IR_BYPASS 4'hF
`define BST_IR_CAPTURE 4'h1
`define BST_ID_W 32
`define BST_ID_VER_W 4
`define BST_ID_PART_W 16
`define BST_ID_MAKER_W 11
`define BST_ID_MARK 1'b1
`define BST_BYP_CAPTURE 1'b0
`endif

// [bst_pkg.sv]
// types for the boundary-scan test logic
// assumes bst_defs.svh is on the include path
package bst_pkg;
  // test access controller states
  typedef enum logic [3:0] {
    TAP_TLR, TAP_RTI, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
    TAP_PA_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR,
    TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
  } bst_tap_t;
  // selected test data register
  typedef enum logic [1:0] {SEL_BSR, SEL_ID, SEL_BYP} bst_sel_t;
endpackage : bst_pkg

// [bst_sync.sv]
// two-stage level synchroniser, one per bit
// assumes inputs are levels held for several destination clocks
`timescale 1ns/1ns
module bst_sync #(
  parameter int W = 1
) (
  // destination clock
  input wire logic clk,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  always_ff @(posedge clk) begin
    meta_reg <= d;
    sync_reg <= meta_reg;
  end
  assign q = sync_reg;
endmodule : bst_sync

// [bst_tap_top.sv]
// boundary-scan test logic: controller, instruction, data registers, pins
// assumes TCK from an external tester, MCLK for the core side pins
`timescale 1ns/1ns
`include "bst_defs.svh"
module bst_tap_top #(
  parameter int N_IN = 4,
  parameter int N_IO = 4,
  // identification values are arbitrary
  parameter logic [`BST_ID_VER_W-1:0] ID_VERSION = 4'hA,
  parameter logic [`BST_ID_PART_W-1:0] ID_PART = 16'hC35A,
  parameter logic [`BST_ID_MAKER_W-1:0] ID_MAKER = 11'h2B6
) (
  // system clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // scan port
  input wire logic TCK,
  input wire logic TMS,
  input wire logic TDI,
  input wire logic TRST_N,
  output logic TDO,
  output logic TDO_OE,
  // function pins
  input wire logic [N_IN-1:0] PIN_IN,
  input wire logic TSTATE_N,
  input wire logic [N_IO-1:0] IO_PIN_I,
  output logic [N_IO-1:0] IO_PIN_O,
  output logic [N_IO-1:0] IO_PIN_OE,
  // core side
  input wire logic [N_IO-1:0] CORE_O,
  input wire logic [N_IO-1:0] CORE_OE,
  output logic [N_IN-1:0] CORE_IN,
  output logic [N_IO-1:0] CORE_IO_IN
);
  localparam int P_TS = N_IN;
  localparam int P_IOI = N_IN + 1;
  localparam int P_IOO = P_IOI + N_IO;
  localparam int P_IOE = P_IOO + N_IO;
  localparam int L = P_IOE + N_IO;
  localparam int NPIN = N_IN + 1 + N_IO;
  localparam int NCAP = NPIN + 2 * N_IO;
  localparam logic [`BST_ID_W-1:0] ID_VALUE =
    {ID_VERSION, ID_PART, ID_MAKER, `BST_ID_MARK};

  // data register selected by an instruction
  function automatic bst_pkg::bst_sel_t sel_f(input logic [3:0] ir);
    if (ir == `BST_IR_EXTEST || ir == `BST_IR_SAMPLE) begin
      sel_f = bst_pkg::SEL_BSR;
    end else if (ir == `BST_IR_IDCODE) begin
      sel_f = bst_pkg::SEL_ID;
    end else begin
      sel_f = bst_pkg::SEL_BYP;
    end
  endfunction : sel_f

  // instruction that floats the outputs
  function automatic logic hiz_f(input logic [3:0] ir);
    hiz_f = !(ir == `BST_IR_EXTEST || ir == `BST_IR_IDCODE ||
              ir == `BST_IR_SAMPLE || ir == `BST_IR_BYPASS);
  endfunction : hiz_f

  // ---------------- TCK domain ----------------
  logic trst_n_s;
  logic [NCAP-1:0] cap_s;
  logic tck_rst;
  bst_pkg::bst_tap_t tap_q;
  bst_pkg::bst_tap_t tap_next;
  logic [`BST_IR_W-1:0] ir_sh;
  logic [`BST_IR_W-1:0] ir_q;
  logic [L-1:0] bsr_sh;
  logic [L-1:0] bsr_upd;
  logic [`BST_ID_W-1:0] id_sh;
  logic byp_q;
  logic tdo_reg;
  logic tdo_oe_reg;
  logic upd_tgl_reg;

  bst_sync #(.W(1)) u_trst_sync (
    .clk(TCK),
    .d(TRST_N),
    .q(trst_n_s)
  );
  bst_sync #(.W(NCAP)) u_cap_sync (
    .clk(TCK),
    .d({CORE_OE, CORE_O, IO_PIN_I, TSTATE_N, PIN_IN}),
    .q(cap_s)
  );

  assign tck_rst = !trst_n_s;

  // controller next state
  always_comb begin
    tap_next = tap_q;
    case (tap_q)
      bst_pkg::TAP_TLR: tap_next = TMS ? bst_pkg::TAP_TLR : bst_pkg::TAP_RTI;
      bst_pkg::TAP_RTI: tap_next = TMS ? bst_pkg::TAP_SEL_DR : bst_pkg::TAP_RTI;
      bst_pkg::TAP_SEL_DR: tap_next = TMS ? bst_pkg::TAP_SEL_IR
                                          : bst_pkg::TAP_CAP_DR;
      bst_pkg::TAP_CAP_DR: tap_next = TMS ? bst_pkg::TAP_EX1_DR
                                          : bst_pkg::TAP_SH_DR;
      bst_pkg::TAP_SH_DR: tap_next = TMS ? bst_pkg::TAP_EX1_DR
                                         : bst_pkg::TAP_SH_DR;
      bst_pkg::TAP_EX1_DR: tap_next = TMS ? bst_pkg::TAP_UPD_DR
                                          : bst_pkg::TAP_PA_DR;
      bst_pkg::TAP_PA_DR: tap_next = TMS ? bst_pkg::TAP_EX2_DR
                                         : bst_pkg::TAP_PA_DR;
      bst_pkg::TAP_EX2_DR: tap_next = TMS ? bst_pkg::TAP_UPD_DR
                                          : bst_pkg::TAP_SH_DR;
      bst_pkg::TAP_UPD_DR: tap_next = TMS ? bst_pkg::TAP_SEL_DR
                                          : bst_pkg::TAP_RTI;
      bst_pkg::TAP_SEL_IR: tap_next = TMS ? bst_pkg::TAP_TLR
                                          : bst_pkg::TAP_CAP_IR;
      bst_pkg::TAP_CAP_IR: tap_next = TMS ? bst_pkg::TAP_EX1_IR
                                          : bst_pkg::TAP_SH_IR;
      bst_pkg::TAP_SH_IR: tap_next = TMS ? bst_pkg::TAP_EX1_IR
                                         : bst_pkg::TAP_SH_IR;
      bst_pkg::TAP_EX1_IR: tap_next = TMS ? bst_pkg::TAP_UPD_IR
                                          : bst_pkg::TAP_PA_IR;
      bst_pkg::TAP_PA_IR: tap_next = TMS ? bst_pkg::TAP_EX2_IR
                                         : bst_pkg::TAP_PA_IR;
      bst_pkg::TAP_EX2_IR: tap_next = TMS ? bst_pkg::TAP_UPD_IR
                                          : bst_pkg::TAP_SH_IR;
      bst_pkg::TAP_UPD_IR: tap_next = TMS ? bst_pkg::TAP_SEL_DR
                                          : bst_pkg::TAP_RTI;
      default: tap_next = bst_pkg::TAP_TLR;
    endcase
  end

  // decode of the current state and instruction
  bst_pkg::bst_sel_t sel;
  logic cap_dr;
  logic sh_dr;
  logic cap_ir;
  logic sh_ir;
  logic upd_dr;
  logic upd_ir;
  logic in_tlr;
  logic upd_evt;
  logic tdo_bit;
  logic [L-1:0] cap_vec;
  assign sel = sel_f(ir_q);
  assign cap_dr = tap_q == bst_pkg::TAP_CAP_DR;
  assign sh_dr = tap_q == bst_pkg::TAP_SH_DR;
  assign cap_ir = tap_q == bst_pkg::TAP_CAP_IR;
  assign sh_ir = tap_q == bst_pkg::TAP_SH_IR;
  assign upd_dr = tap_q == bst_pkg::TAP_UPD_DR;
  assign upd_ir = tap_q == bst_pkg::TAP_UPD_IR;
  assign in_tlr = tap_q == bst_pkg::TAP_TLR;
  // pins and core drive after the two-stage TCK synchroniser; one cell per pin and enable
  assign cap_vec = cap_s;

  // next values of the shift stages
  logic [`BST_IR_W-1:0] ir_sh_next;
  logic [L-1:0] bsr_sh_next;
  logic [`BST_ID_W-1:0] id_sh_next;
  logic byp_next;
  logic bsr_on;
  logic id_on;
  logic byp_on;
  assign bsr_on = sel == bst_pkg::SEL_BSR;
  assign id_on = sel == bst_pkg::SEL_ID;
  assign byp_on = sel == bst_pkg::SEL_BYP;
  assign ir_sh_next = cap_ir ? `BST_IR_CAPTURE :
                      sh_ir ? {TDI, ir_sh[`BST_IR_W-1:1]} : ir_sh;
  assign bsr_sh_next = (bsr_on && cap_dr) ? cap_vec :
                       (bsr_on && sh_dr) ? {TDI, bsr_sh[L-1:1]} :
                       bsr_sh;
  assign id_sh_next = (id_on && cap_dr) ? ID_VALUE :
                      (id_on && sh_dr) ? {TDI, id_sh[`BST_ID_W-1:1]} : id_sh;
  assign byp_next = (byp_on && cap_dr) ? `BST_BYP_CAPTURE :
                    (byp_on && sh_dr) ? TDI : byp_q;
  assign tdo_bit = sh_ir ? ir_sh[0] :
                   bsr_on ? bsr_sh[0] :
                   id_on ? id_sh[0] : byp_q;
  assign upd_evt = upd_ir || upd_dr ||
                   (in_tlr && ir_q != `BST_IR_IDCODE);

  always_ff @(posedge TCK) begin
    if (tck_rst) begin
      tap_q <= bst_pkg::TAP_TLR;
    end else begin
      tap_q <= tap_next;
    end
  end

  always_ff @(posedge TCK) begin
    ir_sh <= ir_sh_next;
    bsr_sh <= bsr_sh_next;
    id_sh <= id_sh_next;
    byp_q <= byp_next;
  end

  // falling edge: instruction, update stage, TDO
  always_ff @(negedge TCK) begin
    if (tck_rst || in_tlr) begin
      ir_q <= `BST_IR_IDCODE;
    end else if (upd_ir) begin
      ir_q <= ir_sh;
    end
  end

  always_ff @(negedge TCK) begin
    if (tck_rst) begin
      bsr_upd <= '0;
    end else if (upd_dr && bsr_on) begin
      bsr_upd <= bsr_sh;
    end
  end

  always_ff @(negedge TCK) begin
    if (tck_rst) begin
      tdo_reg <= 1'b0;
      tdo_oe_reg <= 1'b0;
      upd_tgl_reg <= 1'b0;
    end else begin
      tdo_reg <= tdo_bit;
      tdo_oe_reg <= sh_dr || sh_ir;
      upd_tgl_reg <= upd_tgl_reg ^ upd_evt;
    end
  end

  assign TDO = tdo_reg;
  assign TDO_OE = tdo_oe_reg;

  // ---------------- MCLK domain ----------------
  logic tgl_m;
  logic tgl_d_reg;
  logic [NPIN-1:0] pin_m;
  logic load_m;
  logic ext_reg;
  logic hiz_reg;
  logic [N_IO-1:0] upd_o_reg;
  logic [N_IO-1:0] upd_oe_reg;
  logic [N_IO-1:0] io_o_reg;
  logic [N_IO-1:0] io_oe_reg;
  logic [N_IO-1:0] io_o_next;
  logic [N_IO-1:0] io_oe_next;
  logic [N_IN-1:0] core_in_reg;
  logic [N_IO-1:0] core_io_in_reg;
  logic tstate_n_m;

  bst_sync #(.W(1)) u_tgl_sync (
    .clk(MCLK),
    .d(upd_tgl_reg),
    .q(tgl_m)
  );
  bst_sync #(.W(NPIN)) u_pin_sync (
    .clk(MCLK),
    .d({IO_PIN_I, TSTATE_N, PIN_IN}),
    .q(pin_m)
  );

  // instruction and update stage are stable when the toggle arrives
  assign load_m = tgl_m ^ tgl_d_reg;
  assign tstate_n_m = pin_m[P_TS];
  assign io_o_next = ext_reg ? upd_o_reg : CORE_O;
  assign io_oe_next = hiz_reg ? '0 :
                      ext_reg ? upd_oe_reg :
                      (CORE_OE & {N_IO{tstate_n_m}});

  always_ff @(posedge MCLK) begin
    if (RST) begin
      tgl_d_reg <= 1'b0;
      ext_reg <= 1'b0;
      hiz_reg <= 1'b0;
      upd_o_reg <= '0;
      upd_oe_reg <= '0;
    end else begin
      tgl_d_reg <= tgl_m;
      if (load_m) begin
        ext_reg <= ir_q == `BST_IR_EXTEST;
        hiz_reg <= hiz_f(ir_q);
        upd_o_reg <= bsr_upd[P_IOO +: N_IO];
        upd_oe_reg <= bsr_upd[P_IOE +: N_IO];
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      io_o_reg <= '0;
      io_oe_reg <= '0;
      core_in_reg <= '0;
      core_io_in_reg <= '0;
    end else begin
      io_o_reg <= io_o_next;
      io_oe_reg <= io_oe_next;
      core_in_reg <= pin_m[N_IN-1:0];
      core_io_in_reg <= pin_m[P_IOI +: N_IO];
    end
  end

  assign IO_PIN_O = io_o_reg;
  assign IO_PIN_OE = io_oe_reg;
  assign CORE_IN = core_in_reg;
  assign CORE_IO_IN = core_io_in_reg;

  // ---------------- checks ----------------
  chk_tlr_five: assert property (
    @(posedge TCK) disable iff (tck_rst)
    TMS [*5] |=> tap_q == bst_pkg::TAP_TLR)
    else $error("five TMS highs did not reach reset state");

  chk_ir_reset: assert property (
    @(negedge TCK) disable iff (tck_rst)
    in_tlr |=> ir_q == `BST_IR_IDCODE)
    else $error("reset state did not load IDCODE");

  chk_ir_capture: assert property (
    @(posedge TCK) disable iff (tck_rst)
    cap_ir |=> ir_sh == `BST_IR_CAPTURE)
    else $error("capture-IR pattern wrong");

  chk_bsr_capture: assert property (
    @(posedge TCK) disable iff (tck_rst)
    cap_dr && bsr_on |=> bsr_sh == $past(cap_vec))
    else $error("boundary chain did not capture pins");

  chk_bsr_shift: assert property (
    @(posedge TCK) disable iff (tck_rst)
    sh_dr && bsr_on |=> bsr_sh[L-1] == $past(TDI))
    else $error("boundary chain did not shift TDI in");

  chk_id_load: assert property (
    @(posedge TCK) disable iff (tck_rst)
    cap_dr && id_on |=> id_sh == ID_VALUE && id_sh[0] == 1'b1)
    else $error("identification value not captured");

  chk_byp_zero: assert property (
    @(posedge TCK) disable iff (tck_rst)
    cap_dr && byp_on ##1 sh_dr |-> (TDO == 1'b0 && TDO_OE))
    else $error("bypass zero not first on TDO");

  chk_byp_hold: assert property (
    @(negedge TCK) disable iff (tck_rst)
    upd_dr && byp_on |=> $stable(bsr_upd))
    else $error("update stage changed under bypass");

  chk_tdo_enable: assert property (
    @(posedge TCK) disable iff (tck_rst)
    TDO_OE |-> (sh_dr || sh_ir))
    else $error("TDO driven outside shift states");

  chk_hiz_float: assert property (
    @(posedge MCLK) disable iff (RST)
    hiz_reg && !load_m |=> hiz_reg && IO_PIN_OE == '0)
    else $error("outputs not floating under high impedance");

  chk_ext_drive: assert property (
    @(posedge MCLK) disable iff (RST)
    ext_reg && !load_m |=> IO_PIN_OE == upd_oe_reg && IO_PIN_O == upd_o_reg)
    else $error("EXTEST outputs not from update stage");
endmodule : bst_tap_top

// [bst_jtag_host.sv]
// scan tester model: drives the scan port and reports TDO per scan
// assumes TDO moves on falling TCK; sampled here on rising TCK
`timescale 1ns/1ns
module bst_jtag_host (
  // scan port
  output logic TCK,
  output logic TMS,
  output logic TDI,
  output logic TRST_N,
  input wire logic TDO,
  // results
  output logic res_stb,
  output logic [63:0] res_val
);
  logic active;
  logic tdo_smp;
  initial begin
    TCK = 1'b0;
    TMS = 1'b1;
    TDI = 1'b0;
    TRST_N = 1'b0;
    active = 1'b0;
    res_stb = 1'b0;
    res_val = '0;
    tdo_smp = 1'b0;
    #3;
    forever begin
      #24;
      if (active || TCK) TCK = ~TCK;
    end
  end
  // one controller step, change after falling edge
  task automatic step(input logic m, input logic d);
    @(negedge TCK);
    #1;
    TMS = m;
    TDI = d;
    @(posedge TCK);
    tdo_smp = TDO;
    // leave the sampling edge before anything else moves
    #1;
  endtask : step
  // capture, shift n bits LSB first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [63:0] din);
    logic [63:0] q;
    q = '0;
    active = 1'b1;
    step(1'b1, ~TDI);
    if (ir) step(1'b1, ~TDI);
    step(1'b0, ~TDI);
    step(1'b0, ~TDI);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i]);
      q[i] = tdo_smp;
    end
    step(1'b1, ~TDI);
    step(1'b0, ~TDI);
    active = 1'b0;
    res_val = q;
    res_stb = ~res_stb;
  endtask : scan
  task automatic trst();
    active = 1'b1;
    TRST_N = 1'b0;
    repeat (4) step(1'b0, ~TDI);
    TRST_N = 1'b1;
    repeat (4) step(1'b0, ~TDI);
    active = 1'b0;
  endtask : trst
  task automatic tlr5();
    active = 1'b1;
    repeat (5) step(1'b1, ~TDI);
    step(1'b0, ~TDI);
    active = 1'b0;
  endtask : tlr5
endmodule : bst_jtag_host

// [boundary_scan_test_logic_tb_top.sv]
// self-checking bench for the boundary-scan test logic
// assumes the tester model drives the scan port
`timescale 1ns/1ns
module boundary_scan_test_logic_tb_top;
  localparam int L = 17;
  localparam logic [63:0] ID = {32'h0, 4'hA, 16'hC35A, 11'h2B6, 1'b1};
  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic TCK, TMS, TDI, TRST_N, TDO, TDO_OE, TSTATE_N = 1'b1;
  logic [3:0] PIN_IN = '0, IO_PIN_I = '0, CORE_O = '0, CORE_OE = '0;
  logic [3:0] IO_PIN_O, IO_PIN_OE, CORE_IN, CORE_IO_IN;
  logic res_stb;
  logic [63:0] res_val, pre;
  logic [63:0] exp_q[$];
  int error_cnt = 0;
  int n_checks = 0;
  always #4 MCLK = ~MCLK;
  bst_tap_top #(.N_IN(4), .N_IO(4), .ID_VERSION(4'hA),
    .ID_PART(16'hC35A), .ID_MAKER(11'h2B6)) DUT (.MCLK(MCLK),
    .RST(RST), .TCK(TCK), .TMS(TMS), .TDI(TDI), .TRST_N(TRST_N),
    .TDO(TDO), .TDO_OE(TDO_OE), .PIN_IN(PIN_IN), .TSTATE_N(TSTATE_N),
    .IO_PIN_I(IO_PIN_I), .IO_PIN_O(IO_PIN_O), .IO_PIN_OE(IO_PIN_OE),
    .CORE_O(CORE_O), .CORE_OE(CORE_OE), .CORE_IN(CORE_IN),
    .CORE_IO_IN(CORE_IO_IN));
  // a released TDO shows the inverse of its last value
  bst_jtag_host host (.TCK(TCK), .TMS(TMS), .TDI(TDI), .TRST_N(TRST_N),
    .TDO(TDO_OE ? TDO : ~TDO), .res_stb(res_stb), .res_val(res_val));
  task automatic chk(input logic [63:0] seen, input logic [63:0] want);
    n_checks++;
    if (seen !== want) begin
      error_cnt++;
      $display("ERROR %0t: got %h want %h", $time, seen, want);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic mw(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask : mw
  // note the expected scan result, then run the scan
  task automatic sc(input logic ir, input int n, input logic [63:0] din,
    input logic [63:0] want);
    exp_q.push_back(want & ((64'h1 << n) - 64'h1));
    host.scan(ir, n, din);
  endtask : sc
  function automatic logic [63:0] cap_vec();
    return {47'h0, CORE_OE, CORE_O, IO_PIN_I, TSTATE_N, PIN_IN};
  endfunction : cap_vec
  task automatic rand_pins();
    mw(1);
    PIN_IN = 4'($urandom);
    IO_PIN_I = 4'($urandom);
    CORE_O = 4'($urandom);
    CORE_OE = 4'($urandom);
  endtask : rand_pins
  // the strobe settling at time zero is not a result
  always @(res_stb) begin
    if ($time > 0) begin
      if (exp_q.size() == 0) chk(res_val, 64'hFFFF_FFFF_FFFF_FFFF);
      else chk(res_val, exp_q.pop_front());
    end
  end
  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    logic [63:0] pat;
    void'($urandom(23));
    mw(8);
    RST = 1'b0;
    host.trst();
    chk(TDO_OE, 1'b0);
    sc(1'b0, 32, 64'h0, ID);
    sc(1'b1, 4, 64'hF, 64'h1);
    pat = 64'($urandom);
    sc(1'b0, 8, pat, {pat[6:0], 1'b0});
    rand_pins();
    mw(6);
    chk(IO_PIN_OE, CORE_OE);
    chk(IO_PIN_O, CORE_O);
    chk(CORE_IN, PIN_IN);
    chk(CORE_IO_IN, IO_PIN_I);
    sc(1'b1, 4, 64'h5, 64'h1);
    rand_pins();
    mw(6);
    pre = 64'($urandom);
    sc(1'b0, L, pre, cap_vec());
    mw(6);
    chk(IO_PIN_OE, CORE_OE);
    TSTATE_N = 1'b0;
    sc(1'b1, 4, 64'h0, 64'h1);
    mw(6);
    chk(IO_PIN_O, pre[12:9]);
    chk(IO_PIN_OE, pre[16:13]);
    rand_pins();
    mw(6);
    chk(IO_PIN_O, pre[12:9]);
    pat = 64'($urandom);
    sc(1'b0, L, pat, cap_vec());
    mw(6);
    chk(IO_PIN_O, pat[12:9]);
    chk(IO_PIN_OE, pat[16:13]);
    TSTATE_N = 1'b1;
    CORE_OE = 4'hF;
    sc(1'b1, 4, 64'h4, 64'h1);
    mw(6);
    chk(IO_PIN_OE, 4'h0);
    sc(1'b0, 2, 64'h3, 64'h2);
    mw(6);
    chk(IO_PIN_OE, 4'h0);
    sc(1'b1, 4, 64'h3, 64'h1);
    mw(6);
    chk(IO_PIN_OE, 4'h0);
    sc(1'b0, 2, 64'h3, 64'h2);
    host.tlr5();
    mw(6);
    chk(IO_PIN_OE, CORE_OE);
    sc(1'b0, 32, 64'h0, ID);
    mw(2);
    chk(TDO_OE, 1'b0);
    chk(exp_q.size(), 64'h0);
    give_verdict();
  end
endmodule : boundary_scan_test_logic_tb_top
